// >>> common/ioc_pkg.sv
// Package: register map, field layout and carrier types of the change-interrupt block
package ioc_pkg;

    localparam int unsigned DATA_W = 8;

    // Register indices as seen by the serial register engine
    localparam logic [7:0] ADDR_DIRECTION    = 8'h00;
    localparam logic [7:0] ADDR_CHANGE_EN    = 8'h02;
    localparam logic [7:0] ADDR_COMPARE_VAL  = 8'h03;
    localparam logic [7:0] ADDR_COMPARE_SRC  = 8'h04;
    localparam logic [7:0] ADDR_CONFIG       = 8'h05;
    localparam logic [7:0] ADDR_FLAGS        = 8'h07;
    localparam logic [7:0] ADDR_CAPTURE      = 8'h08;
    localparam logic [7:0] ADDR_PORT         = 8'h09;
    localparam logic [7:0] ADDR_LAST         = 8'h0a;

    // Configuration register fields
    localparam int unsigned CFG_SEQ_DIS_BIT  = 5;
    localparam int unsigned CFG_OD_BIT       = 2;
    localparam int unsigned CFG_POL_BIT      = 1;
    localparam int unsigned CFG_CLR_BIT      = 0;
    localparam logic [7:0]  CFG_IMPL_MASK    = 8'h27;

    localparam logic [7:0]  RST_COMPARE_VAL  = 8'h00;
    localparam logic [7:0]  RST_COMPARE_SRC  = 8'h00;
    localparam logic [7:0]  RST_CONFIG       = 8'h00;
    localparam logic [7:0]  RST_ZERO         = 8'h00;
    localparam logic [7:0]  ADDR_STEP        = 8'h01;

    // One register access from the serial engine
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       rd_lsb_done;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ioc_acc_type;

    // Interrupt pin drive
    typedef struct packed {
        logic out;
        logic oe;
    } ioc_pin_type;

endpackage

// >>> hw/ioc_compare_and_config.sv
// Change-interrupt compare, compare source and configuration registers
`timescale 1ns/1ns

module ioc_compare_and_config #(
    parameter int unsigned WIDTH = ioc_pkg::DATA_W
) (
    input  wire logic               i_sys_clk,
    input  wire logic               i_rst_b,
    input  wire logic [WIDTH-1:0]   i_port_pins,
    input  wire logic [WIDTH-1:0]   i_pin_is_input,
    input  wire logic [WIDTH-1:0]   i_change_irq_enable,
    input  wire ioc_pkg::ioc_acc_type i_acc,
    input  wire logic               i_byte_done,
    input  wire logic               i_addr_load,
    input  wire logic [7:0]         i_addr_load_val,
    output logic [7:0]              o_reg_addr,
    output logic [7:0]              o_rdata,
    output logic [WIDTH-1:0]        o_port_sync,
    output logic [WIDTH-1:0]        o_irq_flags,
    output logic [WIDTH-1:0]        o_captured_port_value,
    output logic                    o_irq_active,
    output logic                    o_irq_out,
    output logic                    o_irq_oe
);

    // ------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------
    logic [WIDTH-1:0] pin_meta_q;
    logic [WIDTH-1:0] pin_sync_q;

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end
        else
        begin
            pin_meta_q <= i_port_pins;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [WIDTH-1:0] default_compare_value_q;
    logic [WIDTH-1:0] compare_source_select_q;
    logic [7:0]       expander_configuration_q;
    logic [WIDTH-1:0] prev_value_q;
    logic [WIDTH-1:0] captured_q;
    logic [WIDTH-1:0] flags_q;
    logic             irq_q;
    logic [7:0]       addr_q;
    logic [7:0]       addr_d;

    wire logic wr_cmp_val = i_acc.wr && (i_acc.addr == ioc_pkg::ADDR_COMPARE_VAL);
    wire logic wr_cmp_src = i_acc.wr && (i_acc.addr == ioc_pkg::ADDR_COMPARE_SRC);
    wire logic wr_cfg     = i_acc.wr && (i_acc.addr == ioc_pkg::ADDR_CONFIG);

    wire logic seq_dis  = expander_configuration_q[ioc_pkg::CFG_SEQ_DIS_BIT];
    wire logic od_sel   = expander_configuration_q[ioc_pkg::CFG_OD_BIT];
    wire logic pol_high = expander_configuration_q[ioc_pkg::CFG_POL_BIT];
    wire logic clr_sel  = expander_configuration_q[ioc_pkg::CFG_CLR_BIT];

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            default_compare_value_q  <= ioc_pkg::RST_COMPARE_VAL;
            compare_source_select_q  <= ioc_pkg::RST_COMPARE_SRC;
            expander_configuration_q <= ioc_pkg::RST_CONFIG;
        end
        else
        begin
            if (wr_cmp_val)
                default_compare_value_q <= i_acc.wdata[WIDTH-1:0];
            if (wr_cmp_src)
                compare_source_select_q <= i_acc.wdata[WIDTH-1:0];
            if (wr_cfg)
                expander_configuration_q <= i_acc.wdata & ioc_pkg::CFG_IMPL_MASK;
        end
    end

    // ------------------------------------------------------------
    // Compare and interrupt
    // ------------------------------------------------------------
    wire logic [WIDTH-1:0] ref_val = (compare_source_select_q & default_compare_value_q)
                                   | (~compare_source_select_q & prev_value_q);
    wire logic [WIDTH-1:0] armed   = i_change_irq_enable & i_pin_is_input;
    wire logic [WIDTH-1:0] mismatch = (pin_sync_q ^ ref_val) & armed;
    wire logic             cond_active = |mismatch;

    wire logic clr_addr_hit = clr_sel ? (i_acc.addr == ioc_pkg::ADDR_CAPTURE)
                                      : (i_acc.addr == ioc_pkg::ADDR_PORT);
    // Flag bits pend only for enabled pins; clear waits for the last bit out
    wire logic clr_req  = i_acc.rd_lsb_done && clr_addr_hit;
    // Level conditions would re-fire at once, so a clear is refused while one holds
    wire logic clr_take = clr_req && irq_q && !cond_active;

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            irq_q        <= 1'b0;
            flags_q      <= ioc_pkg::RST_ZERO[WIDTH-1:0];
            captured_q   <= ioc_pkg::RST_ZERO[WIDTH-1:0];
            prev_value_q <= ioc_pkg::RST_ZERO[WIDTH-1:0];
        end
        else if (!irq_q)
        begin
            if (cond_active)
            begin
                irq_q      <= 1'b1;
                flags_q    <= mismatch;
                captured_q <= pin_sync_q;
            end
        end
        else if (clr_take)
        begin
            irq_q        <= 1'b0;
            flags_q      <= ioc_pkg::RST_ZERO[WIDTH-1:0];
            prev_value_q <= pin_sync_q;
        end
    end

    // Pin-change reference must start at the pin level, else first compare fires
    // spuriously; the reference is loaded on clear only, so an idle reset value
    // of zero means the first high pin reports as a change.

    // ------------------------------------------------------------
    // Register pointer
    // ------------------------------------------------------------
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic hold);
        logic [7:0] n;
        n = a;
        if (!hold)
            n = (a == ioc_pkg::ADDR_LAST) ? ioc_pkg::ADDR_DIRECTION : a + ioc_pkg::ADDR_STEP;
        return n;
    endfunction

    always_comb
    begin
        addr_d = addr_q;
        if (i_addr_load)
            addr_d = i_addr_load_val;
        else if (i_byte_done)
            addr_d = next_addr(addr_q, seq_dis);
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            addr_q <= ioc_pkg::ADDR_DIRECTION;
        else
            addr_q <= addr_d;
    end

    // ------------------------------------------------------------
    // Read data and pin drive
    // ------------------------------------------------------------
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    always_comb
    begin
        rdata_d = ioc_pkg::RST_ZERO;
        case (i_acc.addr)
            ioc_pkg::ADDR_COMPARE_VAL: rdata_d[WIDTH-1:0] = default_compare_value_q;
            ioc_pkg::ADDR_COMPARE_SRC: rdata_d[WIDTH-1:0] = compare_source_select_q;
            ioc_pkg::ADDR_CONFIG:      rdata_d = expander_configuration_q;
            ioc_pkg::ADDR_FLAGS:       rdata_d[WIDTH-1:0] = flags_q;
            ioc_pkg::ADDR_CAPTURE:     rdata_d[WIDTH-1:0] = captured_q;
            default:                   rdata_d = ioc_pkg::RST_ZERO;
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
            rdata_q <= ioc_pkg::RST_ZERO;
        else
            rdata_q <= rdata_d;
    end

    ioc_pkg::ioc_pin_type pin_drv;

    always_comb
    begin
        if (od_sel)
        begin
            pin_drv.out = 1'b0;
            pin_drv.oe  = irq_q;
        end
        else
        begin
            pin_drv.out = pol_high ? irq_q : !irq_q;
            pin_drv.oe  = 1'b1;
        end
    end

    assign o_reg_addr            = addr_q;
    assign o_rdata               = rdata_q;
    assign o_port_sync           = pin_sync_q;
    assign o_irq_flags           = flags_q;
    assign o_captured_port_value = captured_q;
    assign o_irq_active          = irq_q;
    assign o_irq_out             = pin_drv.out;
    assign o_irq_oe              = pin_drv.oe;

endmodule

// >>> sim/ioc_props.sv
// Checker for the change-interrupt block ports
`timescale 1ns/1ns
module ioc_props #(
    parameter int unsigned WIDTH = 8
) (
    input wire logic                 i_sys_clk,
    input wire logic                 i_rst_b,
    input wire logic [WIDTH-1:0]     i_pin_is_input,
    input wire logic [WIDTH-1:0]     i_change_irq_enable,
    input wire ioc_pkg::ioc_acc_type i_acc,
    input wire logic                 i_byte_done,
    input wire logic                 i_addr_load,
    input wire logic [7:0]           o_reg_addr,
    input wire logic [WIDTH-1:0]     o_irq_flags,
    input wire logic [WIDTH-1:0]     o_captured_port_value,
    input wire logic                 o_irq_active,
    input wire logic                 o_irq_out,
    input wire logic                 o_irq_oe
);
    logic [7:0] cfg_q;
    logic       step;
    // Shadow of the config register, since it is not a port
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
        if (!i_rst_b)
            cfg_q <= 8'h00;
        else if (i_acc.wr && i_acc.addr == ioc_pkg::ADDR_CONFIG)
            cfg_q <= i_acc.wdata & ioc_pkg::CFG_IMPL_MASK;
    assign step = i_byte_done && !i_addr_load;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    chk_od_drive: assert property (cfg_q[2] |-> !o_irq_out && o_irq_oe == o_irq_active)
        else $error("open-drain drive wrong");
    chk_pp_polarity: assert property (!cfg_q[2] |-> o_irq_oe
        && o_irq_out == (o_irq_active == cfg_q[1])) else $error("push-pull level wrong");
    chk_ptr_hold: assert property (step && cfg_q[5] |=> $stable(o_reg_addr))
        else $error("pointer moved");
    chk_ptr_step: assert property (step && !cfg_q[5] && o_reg_addr != ioc_pkg::ADDR_LAST
        |=> o_reg_addr == $past(o_reg_addr) + ioc_pkg::ADDR_STEP) else $error("pointer step");
    chk_capture_hold: assert property (o_irq_active && $past(o_irq_active)
        |-> $stable(o_captured_port_value)) else $error("capture changed while pending");
    chk_flag_source: assert property ($rose(o_irq_active) |-> o_irq_flags != '0
        && (o_irq_flags & ~($past(i_pin_is_input) & $past(i_change_irq_enable))) == '0)
        else $error("flag from masked pin");
    chk_clear_select: assert property (o_irq_active && i_acc.rd_lsb_done
        && i_acc.addr != (cfg_q[0] ? ioc_pkg::ADDR_CAPTURE : ioc_pkg::ADDR_PORT)
        |=> o_irq_active) else $error("cleared by wrong register");
    chk_clear_cause: assert property ($fell(o_irq_active) |-> $past(i_acc.rd_lsb_done))
        else $error("cleared without read");
endmodule
bind ioc_compare_and_config ioc_props #(.WIDTH(WIDTH)) u_props (.i_sys_clk, .i_rst_b,
    .i_pin_is_input, .i_change_irq_enable, .i_acc, .i_byte_done, .i_addr_load, .o_reg_addr,
    .o_irq_flags, .o_captured_port_value, .o_irq_active, .o_irq_out, .o_irq_oe);

// >>> sim/ioc_host_model.sv
// Serial host model issuing register accesses and byte strobes
`timescale 1ns/1ns
module ioc_host_model (
    input  wire logic           i_sys_clk,
    output ioc_pkg::ioc_acc_type o_acc = '0,
    output logic                o_byte_done = 1'b0,
    output logic                o_addr_load = 1'b0,
    output logic [7:0]          o_addr_load_val = 8'h00
);
    // Address stays after the strobe: read data follows it
    task automatic pulse(input logic wr, input logic lsb, input logic [7:0] a,
                         input logic [7:0] d);
        @(posedge i_sys_clk);
        #1;
        o_acc = {wr, !wr && !lsb, lsb, a, d};
        @(posedge i_sys_clk);
        #1;
        o_acc.wr = 1'b0;
        o_acc.rd_lsb_done = 1'b0;
    endtask
    task automatic step(input logic load, input logic [7:0] v);
        @(posedge i_sys_clk);
        #1;
        o_addr_load = load;
        o_addr_load_val = v;
        o_byte_done = !load;
        @(posedge i_sys_clk);
        #1;
        o_addr_load = 1'b0;
        o_byte_done = 1'b0;
    endtask
endmodule

// >>> sim/testbench.sv
// Testbench: register, pointer and change-interrupt sequences
`timescale 1ns/1ns
module testbench;
    logic                 i_sys_clk = 1'b0, i_rst_b = 1'b0;
    logic [7:0]           i_port_pins = 8'h00, i_pin_is_input = 8'hff, i_change_irq_enable = 8'h00;
    ioc_pkg::ioc_acc_type i_acc;
    logic                 i_byte_done, i_addr_load, irq, ioe, iout;
    logic [7:0]           i_addr_load_val, ra, rd, flg, cap, psync;
    int                   err_count = 0, checks = 0;
    always #5 i_sys_clk = ~i_sys_clk;
    ioc_host_model u_host (.i_sys_clk, .o_acc(i_acc), .o_byte_done(i_byte_done),
        .o_addr_load(i_addr_load), .o_addr_load_val(i_addr_load_val));
    ioc_compare_and_config u_dut (.i_sys_clk, .i_rst_b, .i_port_pins, .i_pin_is_input,
        .i_change_irq_enable, .i_acc, .i_byte_done, .i_addr_load, .i_addr_load_val,
        .o_reg_addr(ra), .o_rdata(rd), .o_port_sync(psync), .o_irq_flags(flg),
        .o_captured_port_value(cap), .o_irq_active(irq), .o_irq_out(iout), .o_irq_oe(ioe));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        u_host.pulse(1'b0, 1'b0, a, 8'h00);
        chk(rd, e);
    endtask
    // Four edges: two sync stages, one to set, one spare
    task automatic pin(input logic [7:0] v);
        @(posedge i_sys_clk);
        #1 i_port_pins = v;
        repeat (4) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks=%0d errors=%0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        #100000 err_count++;
        finish_test();
    end
    initial
    begin
        repeat (3) @(posedge i_sys_clk);
        #1;
        chk({6'h00, ioe, iout}, 8'h03);
        i_rst_b = 1'b1;
        rdc(8'h03, 8'h00);
        rdc(8'h04, 8'h00);
        rdc(8'h05, 8'h00);
        u_host.pulse(1'b1, 1'b0, 8'h05, 8'hff);
        rdc(8'h05, 8'hff & ioc_pkg::CFG_IMPL_MASK);
        u_host.pulse(1'b1, 1'b0, 8'h03, 8'ha5);
        rdc(8'h03, 8'ha5);
        rdc(8'h0c, 8'h00);
        u_host.pulse(1'b1, 1'b0, 8'h05, 8'h00);
        u_host.pulse(1'b1, 1'b0, 8'h03, 8'h00);
        $display("registers done");
        u_host.step(1'b1, 8'h03);
        u_host.step(1'b0, 8'h00);
        chk(ra, 8'h04);
        u_host.step(1'b1, 8'h0a);
        u_host.step(1'b0, 8'h00);
        chk(ra, 8'h00);
        u_host.pulse(1'b1, 1'b0, 8'h05, 8'h20);
        u_host.step(1'b0, 8'h00);
        chk(ra, 8'h00);
        $display("pointer done");
        u_host.pulse(1'b1, 1'b0, 8'h05, 8'h00);
        u_host.pulse(1'b1, 1'b0, 8'h04, 8'h01);
        rdc(8'h04, 8'h01);
        i_change_irq_enable = 8'h01;
        pin(8'h01);
        chk({flg[6:0], irq}, 8'h03);
        chk({cap[6:0], iout}, 8'h02);
        u_host.pulse(1'b0, 1'b1, 8'h09, 8'h00);
        chk(8'(irq), 8'h01);
        pin(8'h00);
        u_host.pulse(1'b0, 1'b1, 8'h08, 8'h00);
        chk(8'(irq), 8'h01);
        rdc(8'h09, 8'h00);
        chk(8'(irq), 8'h01);
        u_host.pulse(1'b0, 1'b1, 8'h09, 8'h00);
        chk(8'(irq), 8'h00);
        $display("default compare done");
        u_host.pulse(1'b1, 1'b0, 8'h04, 8'h00);
        u_host.pulse(1'b1, 1'b0, 8'h05, 8'h03);
        i_change_irq_enable = 8'h06;
        pin(8'h02);
        chk({flg[6:0], irq}, 8'h05);
        chk(8'(iout), 8'h01);
        chk(psync, 8'h02);
        rdc(8'h07, 8'h02);
        rdc(8'h08, 8'h02);
        pin(8'h06);
        chk(cap, 8'h02);
        u_host.pulse(1'b0, 1'b1, 8'h08, 8'h00);
        chk(8'(irq), 8'h01);
        pin(8'h00);
        u_host.pulse(1'b0, 1'b1, 8'h08, 8'h00);
        chk(8'(irq), 8'h00);
        u_host.pulse(1'b1, 1'b0, 8'h05, 8'h04);
        pin(8'h02);
        chk({6'h00, ioe, iout}, 8'h02);
        pin(8'h00);
        u_host.pulse(1'b0, 1'b1, 8'h09, 8'h00);
        chk({6'h00, ioe, iout}, 8'h00);
        $display("pin change done");
        i_change_irq_enable = 8'h01;
        i_pin_is_input = 8'hfe;
        pin(8'h01);
        chk(8'(irq), 8'h00);
        i_pin_is_input = 8'hff;
        i_change_irq_enable = 8'h00;
        pin(8'h01);
        chk(8'(irq), 8'h00);
        $display("masking done");
        finish_test();
    end
endmodule
